// >>> bench/dual_reload_down_timer_bench.sv
/*
  Self-checking bench for the dual reload down timer.
  Assumes oscillators of 100 ns and 60 ns period from the partner model.
*/
`timescale 1ns/1ps
module dual_reload_down_timer_bench import timer_pkg::*; ;
  typedef struct {bit ch; logic src; logic [1:0] rat; logic [7:0] rld; int cyc;} row_s;
  logic clk, rst_n;
  logic low_osc, high_osc, evt_pin;
  logic [7:0] rld0, rld1, rb0, rb1;
  logic pre0, pre1, run0, run1, chain, mode, pol, nre, src0, src1, psel;
  logic msk0, msk1, clr0, clr1, lrd, hrd, flag0, flag1, irq0, irq1, pulse, sclk;
  logic [1:0] rat0, rat1;
  int err_total = 0;
  int tests_run = 0;
  time t1, t2;
  logic q1, q2;
  logic [1:0] g1, g2;
  logic [7:0] held;
  row_s rows[5] = '{
    '{1'b0, SRC_LOW, RATIO_1, 8'h03, 40}, '{1'b0, SRC_HIGH, RATIO_4, 8'h02, 72},
    '{1'b1, SRC_LOW, RATIO_32, 8'h01, 640}, '{1'b1, SRC_HIGH, RATIO_256, 8'h00, 1536},
    '{1'b1, SRC_LOW, RATIO_1, 8'hFF, 2560}};

  osc_event_source src (.clock_in(clk), .low_osc_out(low_osc), .high_osc_out(high_osc),
    .event_pin_out(evt_pin));

  dual_reload_down_timer #(.REF_CYCLES(8)) uut (
    .CLOCK_IN(clk), .RESETN_IN(rst_n), .LOW_SPEED_OSCILLATOR_IN(low_osc),
    .HIGH_SPEED_OSCILLATOR_IN(high_osc), .EVENT_INPUT_PIN_IN(evt_pin),
    .FIRST_RELOAD_VALUE_IN(rld0), .SECOND_RELOAD_VALUE_IN(rld1),
    .FIRST_COUNTER_PRESET_IN(pre0), .SECOND_COUNTER_PRESET_IN(pre1),
    .FIRST_RUN_CONTROL_IN(run0), .SECOND_RUN_CONTROL_IN(run1), .CHAIN_SELECT_IN(chain),
    .COUNTING_MODE_SELECT_IN(mode), .EVENT_EDGE_POLARITY_IN(pol),
    .NOISE_REJECT_ENABLE_IN(nre), .FIRST_RATIO_SELECT_LO_IN(rat0[0]),
    .FIRST_RATIO_SELECT_HI_IN(rat0[1]), .SECOND_RATIO_SELECT_IN(rat1),
    .FIRST_SOURCE_SELECT_IN(src0), .SECOND_SOURCE_SELECT_IN(src1),
    .PULSE_CHANNEL_SELECT_IN(psel), .FIRST_UNDERFLOW_MASK_IN(msk0),
    .SECOND_UNDERFLOW_MASK_IN(msk1), .FIRST_FLAG_CLEAR_IN(clr0),
    .SECOND_FLAG_CLEAR_IN(clr1), .FIRST_UNDERFLOW_FLAG_OUT(flag0),
    .SECOND_UNDERFLOW_FLAG_OUT(flag1), .FIRST_IRQ_OUT(irq0), .SECOND_IRQ_OUT(irq1),
    .LOW_READ_IN(lrd), .HIGH_READ_IN(hrd), .FIRST_COUNT_READBACK_OUT(rb0),
    .SECOND_COUNT_READBACK_OUT(rb1), .UNDERFLOW_PULSE_OUT(pulse), .SERIAL_CLOCK_OUT(sclk));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Waits for a flag, notes time and toggles, clears the flag, then notes irq
  task automatic wait_flag(input bit ch, output time t, output logic q, output logic [1:0] g);
    for (int i = 0; i < 9000; i++) begin
      step(1);
      if ((ch ? flag1 : flag0) === 1'b1) break;
    end
    t = $time;
    g = {pulse, sclk};
    clr0 = !ch;
    clr1 = ch;
    step(1);
    q = ch ? irq1 : irq0;
    clr0 = 1'b0;
    clr1 = 1'b0;
  endtask

  task automatic preset_both();
    run0 = 1'b0;
    run1 = 1'b0;
    pre0 = 1'b1;
    pre1 = 1'b1;
    step(1);
    pre0 = 1'b0;
    pre1 = 1'b0;
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_n, pre0, pre1, run0, run1, chain, mode, pol, nre, src0, src1, psel} = '0;
    {msk0, msk1, clr0, clr1, lrd, hrd, rat0, rat1} = '0;
    rld0 = 8'h5A;
    rld1 = 8'h00;
    step(6);
    rst_n = 1'b1;
    check("reset count", {rb1, rb0}, {COUNT_RST, COUNT_RST});
    check("reset outs", {flag0, flag1, irq0, irq1, pulse, sclk}, 16'h0000);
    // Preset, then stop holds the count; a low preset strobe does nothing
    preset_both();
    check("preset", rb0, 8'h5A);
    run0 = 1'b1;
    step(45);
    run0 = 1'b0;
    step(3);
    held = rb0;
    // 45 run cycles at one tick per 10 cycles give four or five ticks
    check("counting", rb0 >= 8'h55 && rb0 <= 8'h56, 1'b1);
    rld0 = 8'h11;
    step(60);
    check("stopped", rb0, held);
    $display("test preset_run done");
    // Table rows: measured underflow period, reload, toggles, irq
    foreach (rows[k]) begin
      {src0, src1, rat0, rat1, rld0, rld1} = {rows[k].src, rows[k].src, rows[k].rat,
        rows[k].rat, rows[k].rld, rows[k].rld};
      {psel, msk0, msk1} = {rows[k].ch, 1'b1, 1'b0};
      preset_both();
      {clr0, clr1} = 2'b11;
      step(1);
      {clr0, clr1} = 2'b00;
      run0 = !rows[k].ch;
      run1 = rows[k].ch;
      wait_flag(rows[k].ch, t1, q1, g1);
      wait_flag(rows[k].ch, t2, q2, g2);
      check("period", (t2 - t1) / 10, rows[k].cyc);
      check("pulse toggle", g2[1], !g1[1]);
      check("serial toggle", g2[0], g1[0] ^ rows[k].ch);
      check("irq follows mask", q2, !rows[k].ch);
      $display("test row %0d done", k);
    end
    // Chain: held high byte, borrow, 16-bit period and both flags
    {chain, rat0, src0, rld0, rld1} = {CHAIN_16BIT, RATIO_1, SRC_LOW, 8'h01, 8'h02};
    preset_both();
    run0 = 1'b1;
    step(1);
    lrd = 1'b1;
    step(1);
    lrd = 1'b0;
    step(40);
    check("held high", rb1, 8'h02);
    hrd = 1'b1;
    step(1);
    hrd = 1'b0;
    step(1);
    check("borrowed high", rb1, 8'h01);
    wait_flag(1'b0, t1, q1, g1);
    wait_flag(1'b0, t2, q2, g2);
    check("chain period", (t2 - t1) / 10, 5140);
    check("chain flag", flag1, 1'b1);
    $display("test chain done");
    // Event counting on both edges; ratio and source left at slow values
    {chain, mode, pol, rat0, rat1, rld0, rld1} = {CHAIN_8BIT, MODE_EVENT, EDGE_FALL,
      RATIO_256, RATIO_256, 8'h0A, 8'h0A};
    // Mid-run reset clears the second prescaler, so no timer tick lands in this test
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    check("mid reset count", {rb1, rb0}, {COUNT_RST, COUNT_RST});
    check("mid reset outs", {flag0, flag1, irq0, irq1, pulse, sclk}, 16'h0000);
    preset_both();
    run0 = 1'b1;
    run1 = 1'b1;
    repeat (3) src.pulse(20, 20);
    check("falling count", rb0, 8'h07);
    pol = EDGE_RISE;
    repeat (2) src.pulse(20, 20);
    check("rising count", rb0, 8'h05);
    check("second untouched", rb1, 8'h0A);
    // Noise rejector: a short glitch is dropped, a wide pulse counts once
    {pol, nre} = {EDGE_FALL, 1'b1};
    src.pulse(5, 40);
    check("glitch", rb0, 8'h05);
    src.pulse(40, 40);
    check("filtered", rb0, 8'h04);
    $display("test event done");
    print_verdict();
  end
endmodule // dual_reload_down_timer_bench

// >>> bench/osc_event_source.sv
/*
  Far-side model: two free-running oscillators and an external event source.
  Assumes the bench calls pulse() from its own process.
*/
`timescale 1ns/1ps
module osc_event_source #(
  parameter int LOW_HALF_NS = 50,
  parameter int HIGH_HALF_NS = 30
) (
  // Clock
  input wire logic clock_in,
  // Pins
  output logic low_osc_out,
  output logic high_osc_out,
  output logic event_pin_out
);
  // ----------------------------------------
  // Oscillators
  // ----------------------------------------
  // Half periods avoid the rising system clock edges, so sync latency is fixed
  initial begin
    low_osc_out = 1'b0;
    forever #(LOW_HALF_NS) low_osc_out = ~low_osc_out;
  end
  initial begin
    high_osc_out = 1'b0;
    forever #(HIGH_HALF_NS) high_osc_out = ~high_osc_out;
  end
  // ----------------------------------------
  // Event pulses
  // ----------------------------------------
  initial event_pin_out = 1'b1;
  // Low phase then high phase, idle high afterwards
  task automatic pulse(input int lo_cyc, input int hi_cyc);
    @(posedge clock_in);
    #1 event_pin_out = 1'b0;
    repeat (lo_cyc) @(posedge clock_in);
    #1 event_pin_out = 1'b1;
    repeat (hi_cyc) @(posedge clock_in);
  endtask
endmodule // osc_event_source

// >>> inc/timer_pkg.sv
/*
  Constants shared by the dual reload down timer and its event noise filter.
  Assumes a single 100 MHz system clock.
*/
package timer_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned REF_HZ = 2048;
  localparam int unsigned REF_CYCLES_DEF = CLK_HZ / REF_HZ;
  localparam logic [1:0] NR_ACCEPT_TICKS = 2'h2;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  typedef enum logic {
    MODE_TIMER = 1'b0,
    MODE_EVENT = 1'b1
  } counting_mode_e;

  localparam logic SRC_LOW = 1'b0;
  localparam logic SRC_HIGH = 1'b1;
  localparam logic EDGE_FALL = 1'b0;
  localparam logic EDGE_RISE = 1'b1;
  localparam logic CHAIN_8BIT = 1'b0;
  localparam logic CHAIN_16BIT = 1'b1;
  localparam logic [1:0] RATIO_1 = 2'h0;
  localparam logic [1:0] RATIO_4 = 2'h1;
  localparam logic [1:0] RATIO_32 = 2'h2;
  localparam logic [1:0] RATIO_256 = 2'h3;
  localparam logic [7:0] MASK_1 = 8'h00;
  localparam logic [7:0] MASK_4 = 8'h03;
  localparam logic [7:0] MASK_32 = 8'h1F;
  localparam logic [7:0] MASK_256 = 8'hFF;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic EVT_LEVEL_RST = 1'b1;

endpackage

// >>> verilog/dual_reload_down_timer.sv
/*
  Two 8-bit reload down counters, separate or chained to 16 bits, with
  prescalers, event counting, underflow flags and divided outputs.
  Assumes control inputs come from same-clock logic; oscillator and
  event pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Two 8-bit presettable down counters, configurable
// - Chain select 0: two independent 8-bit channels
// - Preset strobe copies reload value into counter
// - Run gates count clock; stop holds value
// - Low read latches high byte for readback
// - Underflow reloads stored value, counting continues
// - Underflow drives flag, pulse; second channel's also serial clock
// - Timer mode counts prescaler output pulses
// - Mode select: 0 timer, 1 event; reset timer
// - Second channel counts timer mode only
// - Event mode ignores first ratio and source
// - Edge select: 0 falling, 1 rising
// - Noise reject enable turns rejector on
// - Level accepted at second 2048 Hz tick
// - Chain select 1: one 16-bit counter
// - Prescaler divides by 1, 4, 32, 256
// - Source select: 0 low, 1 high oscillator
// - Underflow sets flag regardless of mask
module dual_reload_down_timer import timer_pkg::*; #(
  parameter int unsigned REF_CYCLES = REF_CYCLES_DEF
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  // Pins
  input wire logic LOW_SPEED_OSCILLATOR_IN,
  input wire logic HIGH_SPEED_OSCILLATOR_IN,
  input wire logic EVENT_INPUT_PIN_IN,
  // Reload and strobes
  input wire logic [7:0] FIRST_RELOAD_VALUE_IN,
  input wire logic [7:0] SECOND_RELOAD_VALUE_IN,
  input wire logic FIRST_COUNTER_PRESET_IN,
  input wire logic SECOND_COUNTER_PRESET_IN,
  // Control
  input wire logic FIRST_RUN_CONTROL_IN,
  input wire logic SECOND_RUN_CONTROL_IN,
  input wire logic CHAIN_SELECT_IN,
  input wire logic COUNTING_MODE_SELECT_IN,
  input wire logic EVENT_EDGE_POLARITY_IN,
  input wire logic NOISE_REJECT_ENABLE_IN,
  input wire logic FIRST_RATIO_SELECT_LO_IN,
  input wire logic FIRST_RATIO_SELECT_HI_IN,
  input wire logic [1:0] SECOND_RATIO_SELECT_IN,
  input wire logic FIRST_SOURCE_SELECT_IN,
  input wire logic SECOND_SOURCE_SELECT_IN,
  input wire logic PULSE_CHANNEL_SELECT_IN,
  // Interrupt flags
  input wire logic FIRST_UNDERFLOW_MASK_IN,
  input wire logic SECOND_UNDERFLOW_MASK_IN,
  input wire logic FIRST_FLAG_CLEAR_IN,
  input wire logic SECOND_FLAG_CLEAR_IN,
  output logic FIRST_UNDERFLOW_FLAG_OUT,
  output logic SECOND_UNDERFLOW_FLAG_OUT,
  output logic FIRST_IRQ_OUT,
  output logic SECOND_IRQ_OUT,
  // Readback
  input wire logic LOW_READ_IN,
  input wire logic HIGH_READ_IN,
  output logic [7:0] FIRST_COUNT_READBACK_OUT,
  output logic [7:0] SECOND_COUNT_READBACK_OUT,
  // Divided outputs
  output logic UNDERFLOW_PULSE_OUT,
  output logic SERIAL_CLOCK_OUT
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] ratio_mask(input logic [1:0] sel);
    case (sel)
      RATIO_1: ratio_mask = MASK_1;
      RATIO_4: ratio_mask = MASK_4;
      RATIO_32: ratio_mask = MASK_32;
      RATIO_256: ratio_mask = MASK_256;
      default: ratio_mask = MASK_1;
    endcase
  endfunction

  function automatic logic presc_hit(input logic [7:0] cnt, input logic [1:0] sel);
    presc_hit = (cnt & ratio_mask(sel)) == ratio_mask(sel);
  endfunction

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [2:0] lo_sync_r;
  logic [2:0] hi_sync_r;
  logic [1:0] ev_sync_r;
  logic lo_rise;
  logic hi_rise;

  // Bit 0 feeds only bit 1; edges are taken between bits 1 and 2
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      lo_sync_r <= 3'h0;
      hi_sync_r <= 3'h0;
      ev_sync_r <= {2{EVT_LEVEL_RST}};
    end else begin
      lo_sync_r <= {lo_sync_r[1:0], LOW_SPEED_OSCILLATOR_IN};
      hi_sync_r <= {hi_sync_r[1:0], HIGH_SPEED_OSCILLATOR_IN};
      ev_sync_r <= {ev_sync_r[0], EVENT_INPUT_PIN_IN};
    end
  end

  assign lo_rise = lo_sync_r[1] & ~lo_sync_r[2];
  assign hi_rise = hi_sync_r[1] & ~hi_sync_r[2];

  // ----------------------------------------
  // 2048 Hz reference
  // ----------------------------------------
  logic [15:0] ref_cnt_r;
  logic ref_tick;

  assign ref_tick = ref_cnt_r == 16'(REF_CYCLES - 1);

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      ref_cnt_r <= 16'h0000;
    end else if (ref_tick) begin
      ref_cnt_r <= 16'h0000;
    end else begin
      ref_cnt_r <= ref_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Prescalers
  // ----------------------------------------
  logic [1:0] sel0;
  logic src0;
  logic src1;
  logic [7:0] pre0_r;
  logic [7:0] pre1_r;
  logic pre_tick0;
  logic pre_tick1;

  assign sel0 = {FIRST_RATIO_SELECT_HI_IN, FIRST_RATIO_SELECT_LO_IN};
  assign src0 = (FIRST_SOURCE_SELECT_IN == SRC_HIGH) ? hi_rise : lo_rise;
  assign src1 = (SECOND_SOURCE_SELECT_IN == SRC_HIGH) ? hi_rise : lo_rise;
  assign pre_tick0 = src0 & presc_hit(pre0_r, sel0);
  assign pre_tick1 = src1 & presc_hit(pre1_r, SECOND_RATIO_SELECT_IN);

  // Prescalers advance only while their channel runs
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      pre0_r <= 8'h00;
      pre1_r <= 8'h00;
    end else begin
      if (FIRST_RUN_CONTROL_IN && src0) begin
        pre0_r <= pre0_r + 8'h01;
      end
      if (SECOND_RUN_CONTROL_IN && src1) begin
        pre1_r <= pre1_r + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Event input
  // ----------------------------------------
  logic ev_level;
  logic ev_prev_r;
  logic ev_edge;

  event_noise_filter u_filter (
    .clock_in(CLOCK_IN),
    .resetn_in(RESETN_IN),
    .level_in(ev_sync_r[1]),
    .ref_tick_in(ref_tick),
    .enable_in(NOISE_REJECT_ENABLE_IN),
    .level_out(ev_level)
  );

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      ev_prev_r <= EVT_LEVEL_RST;
    end else begin
      ev_prev_r <= ev_level;
    end
  end

  assign ev_edge = (EVENT_EDGE_POLARITY_IN == EDGE_RISE) ? (ev_level & ~ev_prev_r)
                                                         : (~ev_level & ev_prev_r);

  // ----------------------------------------
  // Count ticks and underflows
  // ----------------------------------------
  logic chained;
  logic tick0;
  logic tick1;
  logic uf16;
  logic uf0;
  logic uf1;
  logic [7:0] cnt0_r;
  logic [7:0] cnt1_r;

  assign chained = CHAIN_SELECT_IN == CHAIN_16BIT;
  // Event mode bypasses the first prescaler entirely
  assign tick0 = FIRST_RUN_CONTROL_IN & ((COUNTING_MODE_SELECT_IN == MODE_EVENT) ? ev_edge
                                                                   : pre_tick0);
  assign tick1 = SECOND_RUN_CONTROL_IN & pre_tick1;
  assign uf16 = tick0 && cnt0_r == 8'h00 && cnt1_r == 8'h00;
  assign uf0 = chained ? uf16 : (tick0 && cnt0_r == 8'h00);
  assign uf1 = chained ? uf16 : (tick1 && cnt1_r == 8'h00);

  // ----------------------------------------
  // Down counters
  // ----------------------------------------
  // Preset wins over a tick in the same cycle; a low strobe does nothing
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      cnt0_r <= COUNT_RST;
    end else if (FIRST_COUNTER_PRESET_IN) begin
      cnt0_r <= FIRST_RELOAD_VALUE_IN;
    end else if (tick0) begin
      cnt0_r <= uf0 ? FIRST_RELOAD_VALUE_IN : cnt0_r - 8'h01;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      cnt1_r <= COUNT_RST;
    end else if (SECOND_COUNTER_PRESET_IN) begin
      cnt1_r <= SECOND_RELOAD_VALUE_IN;
    end else if (chained) begin
      if (uf16) begin
        cnt1_r <= SECOND_RELOAD_VALUE_IN;
      end else if (tick0 && cnt0_r == 8'h00) begin
        cnt1_r <= cnt1_r - 8'h01;
      end
    end else if (tick1) begin
      cnt1_r <= uf1 ? SECOND_RELOAD_VALUE_IN : cnt1_r - 8'h01;
    end
  end

  // ----------------------------------------
  // Readback with high byte hold
  // ----------------------------------------
  logic [7:0] hold_r;
  logic hold_valid_r;

  // Hold lasts until the high byte is read, so reading low first is needed
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      hold_r <= COUNT_RST;
      hold_valid_r <= 1'b0;
    end else if (LOW_READ_IN) begin
      hold_r <= cnt1_r;
      hold_valid_r <= 1'b1;
    end else if (HIGH_READ_IN) begin
      hold_valid_r <= 1'b0;
    end
  end

  assign FIRST_COUNT_READBACK_OUT = cnt0_r;
  assign SECOND_COUNT_READBACK_OUT = hold_valid_r ? hold_r : cnt1_r;

  // ----------------------------------------
  // Flags and requests
  // ----------------------------------------
  logic flag0_r;
  logic flag1_r;
  logic irq0_r;
  logic irq1_r;

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      flag0_r <= FLAG_RST;
      flag1_r <= FLAG_RST;
      irq0_r <= 1'b0;
      irq1_r <= 1'b0;
    end else begin
      flag0_r <= uf0 | (flag0_r & ~FIRST_FLAG_CLEAR_IN);
      flag1_r <= uf1 | (flag1_r & ~SECOND_FLAG_CLEAR_IN);
      irq0_r <= flag0_r & FIRST_UNDERFLOW_MASK_IN;
      irq1_r <= flag1_r & SECOND_UNDERFLOW_MASK_IN;
    end
  end

  assign FIRST_UNDERFLOW_FLAG_OUT = flag0_r;
  assign SECOND_UNDERFLOW_FLAG_OUT = flag1_r;
  assign FIRST_IRQ_OUT = irq0_r;
  assign SECOND_IRQ_OUT = irq1_r;

  // ----------------------------------------
  // Divide-by-two outputs
  // ----------------------------------------
  logic tog0_r;
  logic tog1_r;
  logic pulse_r;

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      tog0_r <= 1'b0;
      tog1_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      tog0_r <= tog0_r ^ uf0;
      tog1_r <= tog1_r ^ uf1;
      pulse_r <= PULSE_CHANNEL_SELECT_IN ? tog1_r : tog0_r;
    end
  end

  assign UNDERFLOW_PULSE_OUT = pulse_r;
  assign SERIAL_CLOCK_OUT = tog1_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  a_preset_loads: assert property (FIRST_COUNTER_PRESET_IN |=>
    cnt0_r == $past(FIRST_RELOAD_VALUE_IN))
    else $error("preset did not load the first reload value");

  a_stop_holds: assert property (!FIRST_RUN_CONTROL_IN && !FIRST_COUNTER_PRESET_IN
    |=> $stable(cnt0_r))
    else $error("stopped first counter changed");

  a_reload_underflow: assert property (uf0 && !FIRST_COUNTER_PRESET_IN
    |=> cnt0_r == $past(FIRST_RELOAD_VALUE_IN))
    else $error("underflow did not reload the first counter");

  a_flag_sets: assert property (uf1 |=> flag1_r ##1 (irq1_r == $past(SECOND_UNDERFLOW_MASK_IN)))
    else $error("second flag or request wrong after underflow");

  a_second_timer_only: assert property (!chained && !SECOND_COUNTER_PRESET_IN
    && !tick1 |=> $stable(cnt1_r))
    else $error("second channel moved without its prescaler");

  a_event_edge: assert property (COUNTING_MODE_SELECT_IN == MODE_EVENT
    && FIRST_RUN_CONTROL_IN && ev_edge && !FIRST_COUNTER_PRESET_IN && cnt0_r != 8'h00
    |=> cnt0_r == $past(cnt0_r) - 8'h01)
    else $error("qualified event edge did not decrement");

  a_high_hold: assert property (LOW_READ_IN ##1 !HIGH_READ_IN [*2]
    |-> SECOND_COUNT_READBACK_OUT == $past(cnt1_r, 2))
    else $error("high byte not held after low read");

  a_chain_borrow: assert property (chained && tick0 && cnt0_r == 8'h00 && cnt1_r != 8'h00
    && !FIRST_COUNTER_PRESET_IN && !SECOND_COUNTER_PRESET_IN
    |=> cnt0_r == 8'hFF && cnt1_r == $past(cnt1_r) - 8'h01)
    else $error("16-bit borrow wrong");

  c_chain_underflow: cover property (chained && uf16);
  c_event_count: cover property (COUNTING_MODE_SELECT_IN == MODE_EVENT && tick0);
  c_second_underflow: cover property (!chained && uf1);
  c_flag_race: cover property (uf0 && FIRST_FLAG_CLEAR_IN);

endmodule // dual_reload_down_timer

// >>> verilog/event_noise_filter.sv
/*
  Noise rejector for the synchronised event input.
  Assumes level_in is already synchronised and ref_tick_in is a one-cycle
  pulse at each falling edge of the 2048 Hz reference.
*/
`timescale 1ns/1ps
module event_noise_filter import timer_pkg::*; (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Level path
  input wire logic level_in,
  input wire logic ref_tick_in,
  input wire logic enable_in,
  output logic level_out
);

  logic level_r;
  logic [1:0] tick_cnt_r;

  // ----------------------------------------
  // Acceptance of a new level
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      level_r <= EVT_LEVEL_RST;
      tick_cnt_r <= 2'h0;
    end else if (!enable_in) begin
      level_r <= level_in;
      tick_cnt_r <= 2'h0;
    end else if (level_in == level_r) begin
      // A glitch that returns before the second tick is forgotten
      tick_cnt_r <= 2'h0;
    end else if (ref_tick_in) begin
      if (tick_cnt_r == NR_ACCEPT_TICKS - 2'h1) begin
        level_r <= level_in;
        tick_cnt_r <= 2'h0;
      end else begin
        tick_cnt_r <= tick_cnt_r + 2'h1;
      end
    end
  end

  assign level_out = level_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_filter_on_tick: assert property (@(posedge clock_in) disable iff (!resetn_in)
    $changed(level_r) && $past(enable_in) |-> $past(ref_tick_in) && $past(tick_cnt_r) == 2'h1)
    else $error("filtered level changed off the second reference tick");

endmodule // event_noise_filter
